// >>> rtl/icg_pkg.sv
// Purpose: shared constants for the carrier generator
// Assumes: 32-bit apb, word-aligned registers
// Notes:   offsets and field positions are local choices
package icg_pkg;
    localparam logic [11:0] OFF_MODE   = 12'h000;
    localparam logic [11:0] OFF_LOW    = 12'h004;
    localparam logic [11:0] OFF_HIGH   = 12'h008;
    localparam logic [11:0] OFF_CTRL   = 12'h00c;
    localparam logic [11:0] OFF_STAT   = 12'h010;
    localparam int          MODE_RUN   = 0;
    localparam int          MODE_CKS   = 4;
    localparam int          CTRL_GATEB = 0;
    localparam int          CTRL_REN   = 1;
    localparam int          CTRL_GATEA = 2;
    localparam logic [7:0]  CMP_RESET  = 8'hff;
    localparam logic [7:0]  CNT_ZERO   = 8'h00;
    localparam logic [1:0]  HIGH_LATCH_CLKS = 2'h3;
    localparam logic [1:0]  XFER_DELAY = 2'h2;
    typedef enum logic [1:0] {XF_IDLE, XF_WAIT1, XF_WAIT2} icg_xfer_t;
endpackage

// >>> rtl/icg_tick_gen.sv
// Purpose: count-clock enable pulses from a prescaler
// Assumes: sel picks sys_clk divided by 2**sel
// Notes:   one-cycle tick; the timer logic stays on sys_clk
`timescale 1ns/100ps
module icg_tick_gen #(
    parameter int PRE_W = 8
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // select and tick
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [PRE_W-1:0] preQ;
    logic [PRE_W:0]   stepV;
    logic [PRE_W:0]   nowV;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            preQ <= '0;
        end else begin
            preQ <= preQ + 1'b1;
        end
    end

    // tick when the low sel bits of the prescaler roll over
    assign stepV = ({1'b0, preQ} + 1'b1);
    assign nowV  = {1'b0, preQ};
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 1'b0;
        end else begin
            tick <= (sel == 3'h0) ? 1'b1 : (stepV[sel] != nowV[sel]);
        end
    end
endmodule // icg_tick_gen

// >>> rtl/icg_sync.sv
// Purpose: two-flop level synchroniser with registered level output
// Assumes: input comes from another timer's clock domain
// Notes:   first flop feeds only the second
`timescale 1ns/100ps
module icg_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // level in, synced level out
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic metaQ;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            metaQ   <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            metaQ   <= asyncIn;
            syncOut <= metaQ;
        end
    end
endmodule // icg_sync

// >>> rtl/icg_carrier_gen.sv
// Purpose: carrier generator mode of an 8-bit timer with frame gating
// Assumes: apb slave, 100 MHz sys_clk, count clock is a prescaled tick
// Notes:   frame event arrives from a separate timer and is synchronised
`timescale 1ns/100ps
module icg_carrier_gen (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // frame timer
    input  wire logic        frameMatchEvent,
    // outputs
    output logic             carrierOutPin,
    output logic             carrierMatchIrq
);
    logic       runQ;
    logic [2:0] clkSelQ;
    logic [7:0] lowCmpQ;
    logic [7:0] highCmpQ;
    logic [7:0] highLatchQ;
    logic       highPendQ;
    logic [1:0] highAgeQ;
    logic       gateBufQ;
    logic       gateActQ;
    logic       remoteEnQ;
    logic [7:0] cntQ;
    logic [8:0] phaseTicksQ;
    logic       useHighQ;
    logic       carrierQ;
    logic       firstTickQ;
    logic       frameSync;
    logic       frameSyncQ;
    logic       strobeQ;
    logic       tick;
    logic       wrEn;
    logic       rdEn;
    logic       match;
    logic       outStartQ;
    icg_pkg::icg_xfer_t xferQ;

    assign wrEn  = psel && penable && pwrite;
    assign rdEn  = psel && !penable && !pwrite;
    assign match = tick && runQ && !firstTickQ && (cntQ == (useHighQ ? highCmpQ : lowCmpQ));

    icg_tick_gen #(.PRE_W(8)) uTick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     (clkSelQ),
        .tick    (tick)
    );

    icg_sync uSync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .asyncIn (frameMatchEvent),
        .syncOut (frameSync)
    );

    // apb: zero wait states, unmapped offsets read zero and flag an error
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == icg_pkg::OFF_MODE || paddr == icg_pkg::OFF_LOW ||
                       paddr == icg_pkg::OFF_HIGH || paddr == icg_pkg::OFF_CTRL || paddr == icg_pkg::OFF_STAT);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (rdEn) begin
            case (paddr)
                icg_pkg::OFF_MODE: prdata <= {24'h0, 1'b0, clkSelQ, 3'h0, runQ};
                icg_pkg::OFF_LOW:  prdata <= {24'h0, lowCmpQ};
                icg_pkg::OFF_HIGH: prdata <= {24'h0, highPendQ ? highLatchQ : highCmpQ};
                icg_pkg::OFF_CTRL: prdata <= {29'h0, gateActQ, remoteEnQ, gateBufQ};
                icg_pkg::OFF_STAT: prdata <= {15'h0, carrierQ, useHighQ, 7'h0, cntQ};
                default:           prdata <= 32'h0;
            endcase
        end else begin
            prdata <= 32'h0;
        end
    end

    // mode, low-width and control writes
    // writes land on the access edge, where pready is sampled high
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            runQ      <= 1'b0;
            clkSelQ   <= 3'h0;
            lowCmpQ   <= icg_pkg::CMP_RESET;
            gateBufQ  <= 1'b0;
            remoteEnQ <= 1'b0;
        end else if (wrEn && pready) begin
            case (paddr)
                icg_pkg::OFF_MODE: begin
                    runQ    <= pwdata[icg_pkg::MODE_RUN];
                    clkSelQ <= pwdata[icg_pkg::MODE_CKS +: 3];
                end
                icg_pkg::OFF_LOW:  lowCmpQ <= pwdata[7:0];
                icg_pkg::OFF_CTRL: begin
                    gateBufQ  <= pwdata[icg_pkg::CTRL_GATEB];
                    remoteEnQ <= pwdata[icg_pkg::CTRL_REN];
                end
                default: ;
            endcase
        end
    end

    // high-width value loaded at once when stopped, else latched and transferred at a high-phase match once three count clocks old
    // age stops at three so a long-pending value cannot wrap back to young
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            highCmpQ   <= icg_pkg::CMP_RESET;
            highLatchQ <= icg_pkg::CMP_RESET;
            highPendQ  <= 1'b0;
            highAgeQ   <= 2'h0;
        end else if (wrEn && pready && paddr == icg_pkg::OFF_HIGH) begin
            highLatchQ <= pwdata[7:0];
            highAgeQ   <= 2'h0;
            if (runQ) begin
                highPendQ <= 1'b1;
            end else begin
                highCmpQ  <= pwdata[7:0];
                highPendQ <= 1'b0;
            end
        end else if (highPendQ) begin
            if (match && useHighQ && highAgeQ == icg_pkg::HIGH_LATCH_CLKS) begin
                highCmpQ  <= highLatchQ;
                highPendQ <= 1'b0;
            end else if (tick && highAgeQ != icg_pkg::HIGH_LATCH_CLKS) begin
                highAgeQ <= highAgeQ + 2'h1;
            end
        end
    end

    // counter, compare select and carrier clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cntQ       <= icg_pkg::CNT_ZERO;
            useHighQ   <= 1'b0;
            carrierQ   <= 1'b0;
            firstTickQ <= 1'b1;
        end else if (!runQ) begin
            cntQ       <= icg_pkg::CNT_ZERO;
            useHighQ   <= 1'b0;
            carrierQ   <= 1'b0;
            firstTickQ <= 1'b1;
        end else if (tick) begin
            firstTickQ <= 1'b0;
            if (match) begin
                cntQ     <= icg_pkg::CNT_ZERO;
                useHighQ <= !useHighQ;
                carrierQ <= !carrierQ;
            end else if (!firstTickQ) begin
                cntQ <= cntQ + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            carrierMatchIrq <= 1'b0;
        end else begin
            carrierMatchIrq <= match && runQ;
        end
    end

    // transfer strobe: rising edge of the synced frame event, on a count tick
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            frameSyncQ <= 1'b0;
            strobeQ    <= 1'b0;
        end else if (tick) begin
            frameSyncQ <= frameSync;
            strobeQ    <= frameSync && !frameSyncQ;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xferQ    <= icg_pkg::XF_IDLE;
            gateActQ <= 1'b0;
        end else if (tick) begin
            case (xferQ)
                icg_pkg::XF_IDLE:  xferQ <= strobeQ ? icg_pkg::XF_WAIT1 : icg_pkg::XF_IDLE;
                icg_pkg::XF_WAIT1: xferQ <= icg_pkg::XF_WAIT2;
                icg_pkg::XF_WAIT2: begin
                    gateActQ <= gateBufQ;
                    xferQ    <= icg_pkg::XF_IDLE;
                end
                default:           xferQ <= icg_pkg::XF_IDLE;
            endcase
        end
    end

    // output gating; gating off never cuts a high pulse short, clearing run does
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outStartQ     <= 1'b0;
            carrierOutPin <= 1'b0;
        end else if (!runQ) begin
            outStartQ     <= 1'b0;
            carrierOutPin <= 1'b0;
        end else if (!gateActQ) begin
            outStartQ     <= 1'b0;
            carrierOutPin <= carrierOutPin && carrierQ;
        end else if (!remoteEnQ) begin
            carrierOutPin <= 1'b1;
        end else begin
            if (!carrierQ) begin
                outStartQ <= 1'b1;
            end
            carrierOutPin <= (outStartQ || !carrierQ) ? carrierQ : carrierOutPin;
        end
    end

    // per-phase tick count kept apart from cntQ, so the length check is not circular
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phaseTicksQ <= 9'h000;
        end else if (!runQ) begin
            phaseTicksQ <= 9'h000;
        end else if (tick && !firstTickQ) begin
            phaseTicksQ <= match ? 9'h000 : phaseTicksQ + 9'h001;
        end
    end

    // steps of the gate transfer and of the carrier start
    sequence s_strobe_take;
        tick && strobeQ && xferQ == icg_pkg::XF_IDLE;
    endsequence
    sequence s_wait_steps;
        (xferQ == icg_pkg::XF_WAIT1) ##1 (xferQ != icg_pkg::XF_IDLE);
    endsequence
    sequence s_xfer_due;
        tick && xferQ == icg_pkg::XF_WAIT2;
    endsequence
    sequence s_gate_live;
        runQ && gateActQ && remoteEnQ && outStartQ;
    endsequence
    sequence s_gate_armed;
        runQ && gateActQ && remoteEnQ && !outStartQ && carrierQ && !carrierOutPin;
    endsequence

    // assertions
    a_irq_on_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
        match |=> carrierMatchIrq) else $error("irq missing after match");
    a_stop_defaults: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !runQ |=> !carrierMatchIrq && !carrierQ) else $error("stop not default");
    a_match_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
        match |=> cntQ == 8'h00) else $error("counter not cleared");
    a_carrier_flip: assert property (@(posedge sys_clk) disable iff (!rst_b)
        match |=> carrierQ != $past(carrierQ)) else $error("carrier not inverted");
    a_gate_low_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!gateActQ && !carrierQ) |=> !carrierOutPin) else $error("output not low");
    a_hold_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (runQ && carrierOutPin && carrierQ && $past(runQ)) |=> carrierOutPin || !carrierQ || !runQ)
        else $error("high pulse cut");
    a_sel_swap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        match |=> useHighQ != $past(useHighQ)) else $error("compare not switched");
    a_no_start_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (runQ && firstTickQ) |-> !match) else $error("match before count");

    // counting and compare switching
    a_irq_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
        carrierMatchIrq |=> !carrierMatchIrq) else $error("irq longer than one cycle");
    a_low_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (runQ && firstTickQ) |-> !useHighQ) else $error("high compare used first");
    a_phase_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
        match |-> phaseTicksQ == {1'b0, (useHighQ ? highCmpQ : lowCmpQ)})
        else $error("phase length wrong");
    a_stop_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !runQ |=> cntQ == icg_pkg::CNT_ZERO && !carrierOutPin) else $error("counter not stopped");
    a_high_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (highPendQ && highAgeQ != icg_pkg::HIGH_LATCH_CLKS && !wrEn) |=> $stable(highCmpQ))
        else $error("high width applied early");
    a_high_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (match && useHighQ && highPendQ && highAgeQ == icg_pkg::HIGH_LATCH_CLKS && !wrEn)
        |=> highCmpQ == $past(highLatchQ)) else $error("high width not applied");

    // frame strobe and gate transfer
    a_strobe_edge: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (tick && frameSync && !frameSyncQ) |=> strobeQ) else $error("strobe missing");
    a_strobe_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (tick && frameSyncQ) |=> !strobeQ) else $error("strobe repeated");
    a_xfer_steps: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_strobe_take |=> s_wait_steps) else $error("transfer wait skipped");
    a_xfer_copy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_xfer_due |=> gateActQ == $past(gateBufQ)) else $error("gate not copied");
    a_gate_readonly: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !(tick && xferQ == icg_pkg::XF_WAIT2) |=> $stable(gateActQ)) else $error("active gate written");

    // output gating
    a_run_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_gate_live |=> carrierOutPin == $past(carrierQ)) else $error("carrier not on pin");
    a_start_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_gate_armed |=> !carrierOutPin) else $error("output started mid pulse");
    a_steady_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (runQ && gateActQ && !remoteEnQ) |=> carrierOutPin) else $error("steady level not high");

    // register port
    a_ready_setup: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (psel && !penable) |=> pready) else $error("ready missing after setup");
    a_ready_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pready |=> !pready) else $error("ready held too long");
    a_err_ready: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pslverr |-> pready) else $error("error without ready");
endmodule // icg_carrier_gen

// >>> verification/icg_frame_model.sv
// Purpose: frame timer stand-in raising match events
// Assumes: one fire pulse from the bench starts one event
// Notes:   event held for many cycles so a slow count clock still sees it
`timescale 1ns/100ps
module icg_frame_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // request and event
    input  wire logic fire,
    output logic      frameMatchEvent
);
    logic [3:0] holdCnt_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_q <= 4'h0;
        end else if (fire) begin
            holdCnt_q <= 4'he;
        end else if (holdCnt_q != 4'h0) begin
            holdCnt_q <= holdCnt_q - 4'h1;
        end
    end

    assign frameMatchEvent = (holdCnt_q != 4'h0);
endmodule // icg_frame_model

// >>> verification/tb_ir_carrier_generator.sv
// Purpose: self-checking bench for the carrier generator
// Assumes: apb slave answers one cycle after setup
// Notes:   count clock select 1, so one tick every two cycles
`timescale 1ns/100ps
module tb_ir_carrier_generator;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} icg_row_t;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fire = 1'b0;
    logic        frameMatchEvent;
    logic        carrierOutPin;
    logic        carrierMatchIrq;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          hi, lo, irqs, hiRun = 0, expHi = 0;
    logic        watchHi = 1'b0;
    icg_row_t    rows [5] = '{
        '{icg_pkg::OFF_LOW, 32'h3, 32'h3, 1'b0},
        '{icg_pkg::OFF_HIGH, 32'h2, 32'h2, 1'b0},
        '{icg_pkg::OFF_CTRL, 32'h7, 32'h3, 1'b0},
        '{icg_pkg::OFF_MODE, 32'h10, 32'h10, 1'b0},
        '{12'h020, 32'h5, 32'h0, 1'b1}};

    icg_carrier_gen DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frameMatchEvent(frameMatchEvent), .carrierOutPin(carrierOutPin), .carrierMatchIrq(carrierMatchIrq));
    icg_frame_model frame (.sys_clk(sys_clk), .rst_b(rst_b), .fire(fire), .frameMatchEvent(frameMatchEvent));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire_event();
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (40) @(posedge sys_clk);
    endtask

    // one full carrier period from a rising edge of the pin
    task automatic measure();
        int n;
        hi = 0;
        lo = 0;
        irqs = 0;
        for (n = 0; n < 300 && carrierOutPin !== 1'b0; n++) @(posedge sys_clk);
        for (n = 0; n < 300 && carrierOutPin !== 1'b1; n++) @(posedge sys_clk);
        while (carrierOutPin === 1'b1 && hi < 300) begin
            hi++;
            irqs += int'(carrierMatchIrq === 1'b1);
            @(posedge sys_clk);
        end
        while (carrierOutPin === 1'b0 && lo < 300) begin
            lo++;
            irqs += int'(carrierMatchIrq === 1'b1);
            @(posedge sys_clk);
        end
    endtask

    // while watchHi is set, every high pulse must keep its full width, even when gated off
    always @(posedge sys_clk) begin
        if (carrierOutPin === 1'b1) begin
            hiRun <= hiRun + 1;
        end else begin
            if (watchHi && hiRun != 0) chk("high width", 32'(hiRun), 32'(expHi));
            hiRun <= 0;
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        chk("out after reset", {30'h0, carrierOutPin, carrierMatchIrq}, 32'h0);
        apb(1'b0, icg_pkg::OFF_LOW, 32'h0);
        chk("low reset", rd, 32'(icg_pkg::CMP_RESET));
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("row read", rd, rows[i].e);
            chk("row err", {31'h0, er}, {31'h0, rows[i].err});
        end
        apb(1'b1, icg_pkg::OFF_MODE, 32'h11);
        apb(1'b0, icg_pkg::OFF_STAT, 32'h0);
        chk("carrier default", rd & 32'h10000, 32'h0);
        chk("gate before event", {31'h0, carrierOutPin}, 32'h0);
        fire_event();
        apb(1'b0, icg_pkg::OFF_CTRL, 32'h0);
        chk("active gate", rd, 32'h7);
        measure();
        chk("high time", 32'(hi), 32'h6);
        chk("low time", 32'(lo), 32'h8);
        chk("irq per period", 32'(irqs), 32'h2);
        apb(1'b1, icg_pkg::OFF_HIGH, 32'h4);
        repeat (60) @(posedge sys_clk);
        measure();
        chk("new high time", 32'(hi), 32'ha);
        chk("low kept", 32'(lo), 32'h8);
        expHi = 10;
        watchHi = 1'b1;
        apb(1'b1, icg_pkg::OFF_CTRL, 32'h2);
        fire_event();
        chk("gated off", {31'h0, carrierOutPin}, 32'h0);
        apb(1'b0, icg_pkg::OFF_CTRL, 32'h0);
        chk("gate cleared", rd, 32'h2);
        watchHi = 1'b0;
        apb(1'b1, icg_pkg::OFF_MODE, 32'h10);
        repeat (4) @(posedge sys_clk);
        irqs = 0;
        repeat (30) begin
            @(posedge sys_clk);
            irqs += int'(carrierMatchIrq !== 1'b0) + int'(carrierOutPin !== 1'b0);
        end
        chk("stopped quiet", 32'(irqs), 32'h0);
        apb(1'b1, icg_pkg::OFF_CTRL, 32'h1);
        apb(1'b1, icg_pkg::OFF_HIGH, 32'h2);
        apb(1'b1, icg_pkg::OFF_MODE, 32'h11);
        fire_event();
        irqs = 0;
        repeat (30) begin
            @(posedge sys_clk);
            irqs += int'(carrierOutPin !== 1'b1);
        end
        chk("steady high", 32'(irqs), 32'h0);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("out in reset", {30'h0, carrierOutPin, carrierMatchIrq}, 32'h0);
        rst_b <= 1'b1;
        apb(1'b0, icg_pkg::OFF_MODE, 32'h0);
        chk("mode after reset", rd, 32'h0);
        report_and_stop();
    end
endmodule // tb_ir_carrier_generator
